// file: host_clr_model.sv
// host model issuing read-and-clear requests
`timescale 1ns/100ps
`default_nettype none
module host_clr_model (
  input wire logic clk_in, // system clock
  output logic stb_out, // clear strobe
  output logic [5:0] addr_out, // status address
  output logic [7:0] mask_out // bits to clear
);
  initial begin
    stb_out = 1'b0;
    addr_out = 6'h00;
    mask_out = 8'h00;
  end
  task automatic clear(input logic [5:0] a, input logic [7:0] m);
    @(negedge clk_in);
    stb_out = 1'b1;
    addr_out = a;
    mask_out = m;
    @(negedge clk_in);
    stb_out = 1'b0;
    addr_out = ~a;
    mask_out = ~m;
  endtask
endmodule // host_clr_model
`default_nettype wire

// file: prot_fault_mgr.sv
// protection, shutdown and fault latch logic
`timescale 1ns/100ps
`default_nettype none

module prot_fault_mgr #(
  parameter int TICK_CYC = prot_pkg::TICK_CYCLES // cycles per trip unit
) (
  input wire logic REF_CLK_IN, // system clock
  input wire logic RST_IN, // async reset, high
  input wire logic UV_CMP_IN, // supply below threshold, pin
  input wire logic TSD_CMP_IN, // die over limit, pin
  input wire logic BYP_DESAT_CMP_IN, // bypass vds beyond limit, pin
  input wire logic FET_ON_REQ_IN, // host fet on command
  input wire logic BYP_ON_REQ_IN, // host bypass on command
  input wire logic STANDBY_IN, // device in standby
  input wire logic ADC_VALID_IN, // new conversion set
  input wire logic [prot_pkg::ADC_W-1:0] ADC_TJ_IN, // die temperature code
  input wire logic [prot_pkg::ADC_W-1:0] ADC_NTC_IN, // thermistor code
  input wire logic [prot_pkg::ADC_W-1:0] ADC_VDS_IN, // drain-source code
  input wire logic [prot_pkg::ADC_W-1:0] ADC_SHUNT_IN, // shunt code
  input wire logic [prot_pkg::ADC_W-1:0] NTC_THR_IN, // thermistor trip code
  input wire logic [prot_pkg::ADC_W-1:0] VDS_THR_IN, // desat trip code
  input wire logic [prot_pkg::ADC_W-1:0] HARD_SHORT_THR_IN, // hard short trip code
  input wire logic [prot_pkg::ADC_W-1:0] OVL_THR_IN, // overload trip code
  input wire logic [prot_pkg::TNOM_W-1:0] TNOM_IN, // trip time in units
  input wire logic FRAME_ACTIVE_IN, // serial frame in progress
  input wire logic CLR_STB_IN, // read-and-clear strobe
  input wire logic [5:0] CLR_ADDR_IN, // read-and-clear address
  input wire logic [prot_pkg::SR_W-1:0] CLR_MASK_IN, // bits to clear
  output logic CP_EN_OUT, // charge pump enable
  output logic GATE_DRIVE_OUT, // external fet gate drive
  output logic BYP_EN_OUT, // bypass switch enable
  output logic [prot_pkg::SR_W-1:0] STATUS_OUT, // status register one
  output logic [7:0] GSB_OUT, // global status byte
  output logic CS_VALID_OUT, // current sense result valid
  output logic [prot_pkg::ADC_W-1:0] TJ_OUT, // stored die temperature
  output logic [prot_pkg::ADC_W-1:0] NTC_OUT, // stored thermistor
  output logic [prot_pkg::ADC_W-1:0] VDS_OUT, // stored drain-source
  output logic [prot_pkg::ADC_W-1:0] SHUNT_OUT, // stored shunt
  output logic OUT_N_A_OUT // wakeup signal, low active
);
  import prot_pkg::*;

  typedef enum logic [2:0] {
    M_RUN = 3'b001,
    M_UV = 3'b010,
    M_TSD = 3'b100
  } mode_t;

  logic uv_s1_ff, uv_s2_ff, ts_s1_ff, ts_s2_ff, bd_s1_ff, bd_s2_ff;
  mode_t mode_ff;
  logic fet_ot_ff, desat_ff, hard_short_latch_ff, ovl_ff, bsat_ff;
  logic [SR_W-1:0] frozen_ff;
  logic [31:0] tick_cnt_ff;
  logic [TNOM_W-1:0] sec_cnt_ff;
  logic fet_cmd, byp_cmd, fet_faulted, clr_sr1;
  logic fet_ot_det, desat_det, hard_short_det, ovl_det, bsat_det;
  logic [SR_W-1:0] live_sr;

  function automatic logic clr_bit(input logic hit, input logic [SR_W-1:0] m, input int b);
    return hit && m[b];
  endfunction

  // two-flop sync for comparator pins
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      uv_s1_ff <= 1'b0;
      uv_s2_ff <= 1'b0;
      ts_s1_ff <= 1'b0;
      ts_s2_ff <= 1'b0;
      bd_s1_ff <= 1'b0;
      bd_s2_ff <= 1'b0;
    end else begin
      uv_s1_ff <= UV_CMP_IN;
      uv_s2_ff <= uv_s1_ff;
      ts_s1_ff <= TSD_CMP_IN;
      ts_s2_ff <= ts_s1_ff;
      bd_s1_ff <= BYP_DESAT_CMP_IN;
      bd_s2_ff <= bd_s1_ff;
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_ff <= M_RUN;
    end else begin
      case (mode_ff)
        M_RUN: begin
          if (uv_s2_ff) mode_ff <= M_UV;
          else if (ts_s2_ff) mode_ff <= M_TSD;
        end
        M_UV: begin
          if (!uv_s2_ff) mode_ff <= ts_s2_ff ? M_TSD : M_RUN;
        end
        M_TSD: begin
          if (uv_s2_ff) mode_ff <= M_UV;
          else if (!ts_s2_ff) mode_ff <= M_RUN;
        end
        default: mode_ff <= M_RUN;
      endcase
    end
  end

  assign fet_faulted = fet_ot_ff || desat_ff || hard_short_latch_ff || ovl_ff;
  assign fet_cmd = FET_ON_REQ_IN && !fet_faulted;
  assign byp_cmd = BYP_ON_REQ_IN && !fet_faulted && !bsat_ff;

  // fet detections gated by fet command
  assign fet_ot_det = fet_cmd && (ADC_NTC_IN < NTC_THR_IN);
  assign desat_det = fet_cmd && (ADC_VDS_IN > VDS_THR_IN);
  assign hard_short_det = fet_cmd && (ADC_SHUNT_IN > HARD_SHORT_THR_IN);
  // bypass detection only with bypass on
  assign bsat_det = BYP_EN_OUT && bd_s2_ff;

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tick_cnt_ff <= 32'h0;
      sec_cnt_ff <= '0;
    end else if (!(fet_cmd && ADC_SHUNT_IN > OVL_THR_IN)) begin
      tick_cnt_ff <= 32'h0;
      sec_cnt_ff <= '0;
    end else if (tick_cnt_ff == 32'(TICK_CYC - 1)) begin
      tick_cnt_ff <= 32'h0;
      if (sec_cnt_ff != TNOM_IN) sec_cnt_ff <= sec_cnt_ff + 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
    end
  end
  assign ovl_det = fet_cmd && (ADC_SHUNT_IN > OVL_THR_IN) && (sec_cnt_ff == TNOM_IN)
    && (TNOM_IN != '0);

  assign clr_sr1 = CLR_STB_IN && (CLR_ADDR_IN == SR1_ADDR || CLR_ADDR_IN == CLR_ALL_ADDR);

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fet_ot_ff <= 1'b0;
      desat_ff <= 1'b0;
      hard_short_latch_ff <= 1'b0;
      ovl_ff <= 1'b0;
      bsat_ff <= 1'b0;
    end else begin
      fet_ot_ff <= fet_ot_det || (fet_ot_ff && !clr_bit(clr_sr1, CLR_MASK_IN, BIT_FET_OT));
      desat_ff <= desat_det || (desat_ff && !clr_bit(clr_sr1, CLR_MASK_IN, BIT_DESAT));
      hard_short_latch_ff <= hard_short_det
        || (hard_short_latch_ff && !clr_bit(clr_sr1, CLR_MASK_IN, BIT_HARD_SHORT));
      // overload held while hard short latched
      ovl_ff <= ovl_det || hard_short_det
        || (hard_short_latch_ff && !clr_bit(clr_sr1, CLR_MASK_IN, BIT_HARD_SHORT))
        || (ovl_ff && !clr_bit(clr_sr1, CLR_MASK_IN, BIT_OVL));
      bsat_ff <= bsat_det || (bsat_ff && !clr_bit(clr_sr1, CLR_MASK_IN, BIT_BYP_SAT));
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CP_EN_OUT <= 1'b0;
      GATE_DRIVE_OUT <= 1'b0;
      BYP_EN_OUT <= 1'b0;
    end else if (mode_ff != M_RUN) begin
      CP_EN_OUT <= 1'b0;
      GATE_DRIVE_OUT <= 1'b0;
      BYP_EN_OUT <= 1'b0;
    end else begin
      CP_EN_OUT <= 1'b1;
      GATE_DRIVE_OUT <= (fet_cmd && !fet_ot_det && !desat_det && !hard_short_det && !ovl_det)
        || ((bsat_det || bsat_ff) && !fet_faulted);
      BYP_EN_OUT <= byp_cmd && !bsat_det && !fet_ot_det && !desat_det && !hard_short_det
        && !ovl_det;
    end
  end

  always_comb begin
    live_sr = SR1_RESET;
    live_sr[BIT_UV] = uv_s2_ff;
    live_sr[BIT_TSD] = (mode_ff == M_TSD);
    live_sr[BIT_FET_OT] = fet_ot_ff;
    live_sr[BIT_DESAT] = desat_ff;
    live_sr[BIT_BYP_SAT] = bsat_ff;
    live_sr[BIT_HARD_SHORT] = hard_short_latch_ff;
    live_sr[BIT_OVL] = ovl_ff;
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      frozen_ff <= SR1_RESET;
      STATUS_OUT <= SR1_RESET;
      GSB_OUT <= 8'h00;
    end else if (!FRAME_ACTIVE_IN) begin
      frozen_ff <= live_sr;
      STATUS_OUT <= live_sr;
      GSB_OUT <= 8'h00;
      GSB_OUT[GSB_FORCED_ON] <= bsat_ff;
    end else begin
      STATUS_OUT <= frozen_ff;
      GSB_OUT[GSB_FORCED_ON] <= frozen_ff[BIT_BYP_SAT];
    end
  end

  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      TJ_OUT <= '0;
      NTC_OUT <= '0;
      VDS_OUT <= '0;
      SHUNT_OUT <= '0;
      CS_VALID_OUT <= 1'b0;
    end else begin
      if (ADC_VALID_IN) begin
        TJ_OUT <= ADC_TJ_IN;
        NTC_OUT <= ADC_NTC_IN;
        VDS_OUT <= ADC_VDS_IN;
        SHUNT_OUT <= ADC_SHUNT_IN;
      end
      CS_VALID_OUT <= (mode_ff != M_UV) && !uv_s2_ff;
    end
  end

  // wakeup indication, held until bypass desat latch cleared
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      OUT_N_A_OUT <= 1'b1;
    end else if (STANDBY_IN && bsat_det) begin
      OUT_N_A_OUT <= 1'b0;
    end else if (!bsat_ff) begin
      OUT_N_A_OUT <= 1'b1;
    end
  end

  // two frame cycles in a row
  sequence s_in_frame;
    FRAME_ACTIVE_IN ##1 FRAME_ACTIVE_IN;
  endsequence
  sequence s_wake_desat;
    STANDBY_IN && bsat_det;
  endsequence

  a_uv_shutdown: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    mode_ff == M_UV |=> !CP_EN_OUT && !GATE_DRIVE_OUT && !BYP_EN_OUT)
    else $error("undervoltage did not shut outputs");
  a_tsd_shutdown: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    mode_ff == M_TSD |=> !CP_EN_OUT && !GATE_DRIVE_OUT && !BYP_EN_OUT)
    else $error("overtemp did not shut outputs");
  a_tsd_flag: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    mode_ff == M_TSD && !FRAME_ACTIVE_IN |=> STATUS_OUT[BIT_TSD])
    else $error("overtemp flag missing");
  a_uv_release: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    mode_ff == M_UV && !uv_s2_ff && !ts_s2_ff |=> mode_ff == M_RUN)
    else $error("undervoltage exit missing");
  a_tsd_restart: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    mode_ff == M_TSD && !uv_s2_ff && !ts_s2_ff |=> mode_ff == M_RUN)
    else $error("overtemp restart missing");
  a_short_sets_ovl: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    hard_short_latch_ff |-> ovl_ff)
    else $error("hard short without overload latch");
  a_latch_hold: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    desat_ff && !clr_sr1 |=> desat_ff)
    else $error("desat latch dropped without clear");
  a_byp_blocked: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    bsat_ff |=> !BYP_EN_OUT)
    else $error("bypass on while desat latched");
  a_forced_on: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    bsat_det && mode_ff == M_RUN && !fet_faulted |=> GATE_DRIVE_OUT && !BYP_EN_OUT)
    else $error("bypass desat did not force fet on");
  a_det_gated: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !FET_ON_REQ_IN && !desat_ff |=> !desat_ff)
    else $error("desat set while fet off");
  a_cs_invalid: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    mode_ff == M_UV |=> !CS_VALID_OUT)
    else $error("current sense valid in undervoltage");
  a_uv_flag: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !FRAME_ACTIVE_IN |=> STATUS_OUT[BIT_UV] == $past(uv_s2_ff))
    else $error("undervoltage flag not live");
  a_gsb_mirror: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !FRAME_ACTIVE_IN |=> GSB_OUT[GSB_FORCED_ON] == $past(bsat_ff))
    else $error("forced-on bit does not mirror latch");
  a_frame_freeze: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_in_frame |=> $stable(STATUS_OUT) && $stable(GSB_OUT))
    else $error("status moved during frame");
  a_wake_flag: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_wake_desat |=> !OUT_N_A_OUT)
    else $error("wakeup flag not driven low");
  a_ntc_trip: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    fet_ot_det |=> fet_ot_ff && !BYP_EN_OUT)
    else $error("thermistor trip not latched");
  a_desat_trip: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    desat_det |=> desat_ff && !BYP_EN_OUT)
    else $error("desat trip not latched");
  a_short_trip: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    hard_short_det |=> hard_short_latch_ff && !BYP_EN_OUT)
    else $error("hard short not latched");
  a_ovl_trip: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    ovl_det |=> ovl_ff && !BYP_EN_OUT)
    else $error("overload trip not latched");
  a_clear_mask: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    clr_sr1 && CLR_MASK_IN[BIT_FET_OT] && !fet_ot_det |=> !fet_ot_ff)
    else $error("masked clear ignored");
  a_clear_all: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    CLR_STB_IN && CLR_ADDR_IN == CLR_ALL_ADDR && CLR_MASK_IN[BIT_DESAT] && !desat_det
    |=> !desat_ff)
    else $error("clear-all ignored");
  a_byp_det_off: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    !BYP_EN_OUT && !bsat_ff |=> !bsat_ff)
    else $error("bypass desat set while bypass off");

endmodule // prot_fault_mgr
`default_nettype wire

// file: prot_pkg.sv
// constants for the protection and fault latch block
package prot_pkg;
  localparam int ADC_W = 10;
  localparam int THR_W = 6;
  localparam int TNOM_W = 9;
  localparam int SR_W = 8;
  // status byte bit positions
  localparam int BIT_UV = 0;
  localparam int BIT_TSD = 1;
  localparam int BIT_FET_OT = 2;
  localparam int BIT_DESAT = 3;
  localparam int BIT_BYP_SAT = 4;
  localparam int BIT_HARD_SHORT = 5;
  localparam int BIT_OVL = 6;
  localparam int GSB_FORCED_ON = 4;
  localparam logic [5:0] CLR_ALL_ADDR = 6'h3f;
  localparam logic [5:0] SR1_ADDR = 6'h11;
  localparam logic [SR_W-1:0] SR1_RESET = 8'h00;
  // overload timer: one trip unit is one second
  localparam int CLK_HZ = 10000000;
  localparam int TRIP_UNIT_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TRIP_UNIT_S;
  localparam logic [THR_W-1:0] DESAT_THR_RESET = 6'h00;
endpackage : prot_pkg

// file: protection_fault_manager_tb.sv
// self-checking bench for the protection block
`timescale 1ns/100ps
`default_nettype none
module protection_fault_manager_tb;
  import prot_pkg::*;
  localparam int TK = 10;
  logic clk = 1'b0, rst = 1'b1, uv = 1'b0, tsd = 1'b0, bsat = 1'b0, fet = 1'b1, bq = 1'b1;
  logic stby = 1'b0, adc_v = 1'b0, frame = 1'b0, probe = 1'b0, stb, cp, gate, byp, csv, ona;
  logic [ADC_W-1:0] tj = 10'h000, ntc = 10'h190, vds = 10'h064, shn = 10'h064;
  logic [ADC_W-1:0] tjo, ntco, vdso, shno;
  logic [TNOM_W-1:0] tnom = 9'h002;
  logic [5:0] caddr;
  logic [7:0] cmask, st, gsb;
  logic [7:0] fm [4] = '{8'h04, 8'h08, 8'h60, 8'h40};
  logic [31:0] r = 32'h6dce1e85;
  int qi[$];
  logic [39:0] qe[$];
  int n_fail = 0, checks = 0, cyc = 0, pid = 0;
  always #50 clk = ~clk;
  prot_fault_mgr #(.TICK_CYC(TK)) dut_u (.REF_CLK_IN(clk), .RST_IN(rst), .UV_CMP_IN(uv),
    .TSD_CMP_IN(tsd), .BYP_DESAT_CMP_IN(bsat), .FET_ON_REQ_IN(fet), .BYP_ON_REQ_IN(bq),
    .STANDBY_IN(stby), .ADC_VALID_IN(adc_v), .ADC_TJ_IN(tj), .ADC_NTC_IN(ntc),
    .ADC_VDS_IN(vds), .ADC_SHUNT_IN(shn), .NTC_THR_IN(10'h064), .VDS_THR_IN(10'h1f4),
    .HARD_SHORT_THR_IN(10'h320), .OVL_THR_IN(10'h258), .TNOM_IN(tnom), .FRAME_ACTIVE_IN(frame),
    .CLR_STB_IN(stb), .CLR_ADDR_IN(caddr), .CLR_MASK_IN(cmask), .CP_EN_OUT(cp),
    .GATE_DRIVE_OUT(gate), .BYP_EN_OUT(byp), .STATUS_OUT(st), .GSB_OUT(gsb),
    .CS_VALID_OUT(csv), .TJ_OUT(tjo), .NTC_OUT(ntco), .VDS_OUT(vdso), .SHUNT_OUT(shno),
    .OUT_N_A_OUT(ona));
  host_clr_model host_u (.clk_in(clk), .stb_out(stb), .addr_out(caddr), .mask_out(cmask));
  function automatic logic [31:0] lf(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // enables, status, forced-on, cs valid, wakeup
  function automatic logic [39:0] sn(logic [2:0] e, logic [7:0] s, logic [1:0] fv);
    return {26'h0, e, s, fv, 1'b1};
  endfunction
  function automatic logic [39:0] pick(int id);
    case (id)
      0: pick = {26'h0, cp, gate, byp, st, gsb[GSB_FORCED_ON], csv, ona};
      1: pick = {tjo, ntco, vdso, shno};
      default: pick = {31'h0, st, ona};
    endcase
  endfunction
  task automatic chk(int id, logic [39:0] seen, logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected snap%0d expected %h seen %h", id, exp, seen);
    end
  endtask
  task automatic note(int id, logic [39:0] e);
    repeat (6) @(negedge clk);
    qi.push_back(id);
    qe.push_back(e);
    probe = 1'b1;
    @(negedge clk);
    probe = 1'b0;
  endtask
  task automatic flt(int k, logic on);
    case (k)
      0: ntc = on ? 10'h050 : 10'h190;
      1: vds = on ? 10'h300 : 10'h064;
      2: shn = on ? 10'h3c0 : 10'h064;
      default: shn = on ? 10'h2bc : 10'h064;
    endcase
    if (k == 3) repeat (30) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // oldest expectation against the settled outputs
  always @(posedge clk) begin
    if (probe) begin
      pid = qi.pop_front();
      chk(pid, pick(pid), qe.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    note(0, sn(3'b111, 8'h00, 2'b01));
    for (int k = 0; k < 3; k++) begin
      r = lf(r);
      tj = r[9:0];
      ntc = {2'b01, r[17:10]};
      vds = {2'b00, r[25:18]};
      shn = {2'b00, r[31:24]};
      adc_v = 1'b1;
      @(negedge clk);
      adc_v = 1'b0;
      note(1, {tj, ntc, vds, shn});
    end
    $display("adc store test done");
    ntc = 10'h190;
    vds = 10'h064;
    shn = 10'h064;
    uv = 1'b1;
    note(0, sn(3'b000, 8'h01, 2'b00));
    uv = 1'b0;
    note(0, sn(3'b111, 8'h00, 2'b01));
    tsd = 1'b1;
    note(0, sn(3'b000, 8'h02, 2'b01));
    tsd = 1'b0;
    note(0, sn(3'b111, 8'h00, 2'b01));
    $display("supply and die test done");
    for (int k = 0; k < 4; k++) begin
      flt(k, 1'b1);
      note(0, sn(3'b100, fm[k], 2'b01));
      host_u.clear(k[0] ? CLR_ALL_ADDR : SR1_ADDR, fm[k]);
      if (k == 3) repeat (30) @(negedge clk);
      note(0, sn(3'b100, fm[k], 2'b01));
      flt(k, 1'b0);
      note(0, sn(3'b100, fm[k], 2'b01));
      if (k == 2) begin
        host_u.clear(SR1_ADDR, 8'h20);
        note(0, sn(3'b100, 8'h40, 2'b01));
      end
      host_u.clear(k[0] ? CLR_ALL_ADDR : SR1_ADDR, fm[k]);
      note(0, sn(3'b111, 8'h00, 2'b01));
    end
    $display("latched fault test done");
    fet = 1'b0;
    vds = 10'h300;
    note(0, sn(3'b101, 8'h00, 2'b01));
    vds = 10'h064;
    bsat = 1'b1;
    note(0, sn(3'b110, 8'h10, 2'b11));
    bsat = 1'b0;
    note(0, sn(3'b110, 8'h10, 2'b11));
    host_u.clear(SR1_ADDR, 8'h10);
    note(0, sn(3'b101, 8'h00, 2'b01));
    bq = 1'b0;
    bsat = 1'b1;
    note(0, sn(3'b100, 8'h00, 2'b01));
    bq = 1'b1;
    stby = 1'b1;
    note(2, {31'h0, 8'h10, 1'b0});
    bsat = 1'b0;
    host_u.clear(SR1_ADDR, 8'h10);
    stby = 1'b0;
    note(2, {31'h0, 8'h00, 1'b1});
    $display("bypass test done");
    frame = 1'b1;
    uv = 1'b1;
    note(2, {31'h0, 8'h00, 1'b1});
    frame = 1'b0;
    note(2, {31'h0, 8'h01, 1'b1});
    uv = 1'b0;
    $display("frame freeze test done");
    tally_and_finish();
  end
endmodule // protection_fault_manager_tb
`default_nettype wire
